// *** hw/sysc_pkg.sv ***
// Package: register map, field positions and reset values of the system configuration block
package sysc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] REFRESH_INTERVAL_OFS = 8'hE2;
    localparam logic [7:0] REFRESH_ENABLE_COUNTER_OFS = 8'hE4;
    localparam logic [7:0] WATCHDOG_CONTROL_OFS = 8'hE6;
    localparam logic [7:0] SYSTEM_CONFIGURATION_OFS = 8'hF0;
    localparam logic [7:0] AUXILIARY_CONFIGURATION_OFS = 8'hF2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] SYSTEM_CONFIGURATION_RESET = 16'h0000;
    localparam logic [15:0] AUXILIARY_CONFIGURATION_RESET = 16'h0000;
    localparam logic [15:0] WDOG_RESET = 16'hC080;
    localparam logic [15:0] REFRESH_EN_RESET = 16'h0000;
    localparam logic [8:0] REFRESH_INTERVAL_RESET = 9'h000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int AUX_PORT1_CTS = 6;
    localparam int AUX_PORT1_RTS = 5;
    localparam int AUX_PORT0_CTS = 4;
    localparam int AUX_PORT0_RTS = 3;
    localparam int AUX_LOWER_WIDTH = 2;
    localparam int AUX_MIDDLE_WIDTH = 1;
    localparam int AUX_IO_WIDTH = 0;
    localparam int AUX_USED_BITS = 7;

    localparam int SYS_POWER_SAVE = 15;
    localparam int SYS_WHOLE_RANGE = 14;
    localparam int SYS_STROBE_SEL = 13;
    localparam int SYS_DEMOD_EN = 12;
    localparam int SYS_CLKB_SRC = 11;
    localparam int SYS_CLKB_LOW = 10;
    localparam int SYS_CLKA_SRC = 9;
    localparam int SYS_CLKA_LOW = 8;
    localparam int SYS_DIV_HI = 2;

    localparam int WD_ENABLE = 15;
    localparam int WD_RESET_SEL = 14;
    localparam int WD_TIMEOUT_FLAG = 13;
    localparam int WD_NMI_FLAG = 12;
    localparam int WD_TEST = 11;
    localparam int WD_COUNT_HI = 7;

    localparam int REF_ENABLE = 15;
    localparam int REF_COUNT_W = 9;

    // ****************************************
    // Watchdog exponents
    // ****************************************
    localparam logic [4:0] WD_EXP_BIT0 = 5'd10;
    localparam logic [4:0] WD_EXP_BIT1 = 5'd20;
    localparam int WD_CNT_W = 27;

    // ****************************************
    // Register bus carrier
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sysc_req_s;

    // Decoded pin-function selections
    typedef struct packed {
        logic port1CtsSelect;
        logic port1RequestOutSelect;
        logic port0CtsSelect;
        logic port0RequestOutSelect;
        logic lowerSpaceByteWidth;
        logic middleSpaceByteWidth;
        logic ioSpaceByteWidth;
        logic middleSelectWholeRange;
        logic strobePinSelect;
        logic pulseDemodEnable;
    } sysc_cfg_s;

endpackage

// *** hw/sysc_clock_divider.sv ***
// Power-save clock divider: produces a one-cycle enable every 2**field processor clocks
module sysc_clock_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic powerSaveEnable,
    input wire logic [2:0] clockDividerField,
    // Divided clock
    output logic divTick,
    output logic divClock
);
    import sysc_pkg::*;

    logic [6:0] divCount_q;
    logic [6:0] divMask;

    assign divMask = 7'(8'h01 << clockDividerField) - 7'h01;

    // Divide only applies with power-save on; otherwise every cycle ticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCount_q <= 7'h00;
        end else if (!powerSaveEnable || (divCount_q & divMask) == divMask) begin
            divCount_q <= 7'h00;
        end else begin
            divCount_q <= divCount_q + 7'h01;
        end
    end

    assign divTick = !powerSaveEnable || (divCount_q & divMask) == divMask;
    // Square wave at the divided rate; with divide by 1 it reads as steady high
    assign divClock = !powerSaveEnable || clockDividerField == 3'h0
                      || !divCount_q[clockDividerField - 3'h1];
endmodule

// *** hw/sysc_config_block.sv ***
// Top level: system configuration, watchdog and refresh counter register bank
module sysc_config_block (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Peripheral register port
    input wire sysc_pkg::sysc_req_s busReq,
    output logic [15:0] busRdata,
    // Interrupt events from the processor core
    input wire logic hwInterrupt,
    input wire logic swInterrupt,
    // Crystal clock, asynchronous to the internal clock
    input wire logic xtalClock,
    // Decoded configuration
    output sysc_pkg::sysc_cfg_s cfg,
    // Clock outputs
    output logic clockOutA,
    output logic clockOutB,
    output logic divTick,
    // Watchdog outcomes
    output logic watchdogNmi,
    output logic watchdogReset,
    // Refresh
    output logic refreshRequest,
    output logic middleChipSelect3IsRefresh
);
    import sysc_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic powerSave_q;
    logic [14:0] sysOptions_q;
    logic [15:0] sysConfig;
    logic [AUX_USED_BITS-1:0] auxConfig_q;
    logic [15:0] wdog_q;
    logic refreshEnable_q;
    logic [REF_COUNT_W-1:0] refreshInterval_q;
    logic [REF_COUNT_W-1:0] refreshCount_q;
    logic [WD_CNT_W-1:0] wdCount_q;
    logic [1:0] xtalSync_q;
    logic divClock;
    logic wdTimeout;
    logic [4:0] wdExponent;
    logic wdResetCause;
    logic clockSelA;
    logic clockSelB;
    logic refreshTerminal;
    logic [15:0] readData;

    // ****************************************
    // Register decode
    // ****************************************
    logic wrSys;
    logic wrAux;
    logic wrWd;
    logic wrRefEn;
    logic wrRefInt;

    // One offset compare shared by every register write
    function automatic logic write_hit(input sysc_req_s req, input logic [7:0] ofs);
        return req.wr && req.addr == ofs;
    endfunction

    assign wrSys = write_hit(busReq, SYSTEM_CONFIGURATION_OFS);
    assign wrAux = write_hit(busReq, AUXILIARY_CONFIGURATION_OFS);
    assign wrWd = write_hit(busReq, WATCHDOG_CONTROL_OFS);
    assign wrRefEn = write_hit(busReq, REFRESH_ENABLE_COUNTER_OFS);
    assign wrRefInt = write_hit(busReq, REFRESH_INTERVAL_OFS);

    // ****************************************
    // Exponent decode
    // ****************************************
    function automatic logic [4:0] wd_exponent(input logic [7:0] count);
        logic [4:0] e;
        e = 5'h00;
        for (int i = 7; i >= 1; i--) begin
            if (count[i]) begin
                e = WD_EXP_BIT1 + 5'(i - 1);
            end
        end
        if (count[0]) begin
            e = WD_EXP_BIT0;
        end
        return e;
    endfunction

    assign wdExponent = wd_exponent(wdog_q[WD_COUNT_HI:0]);

    // ****************************************
    // System configuration
    // ****************************************
    // A hardware interrupt in the same cycle as a write wins, so power-save never sticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powerSave_q <= SYSTEM_CONFIGURATION_RESET[SYS_POWER_SAVE];
        end else if (hwInterrupt) begin
            powerSave_q <= 1'b0;
        end else if (wrSys) begin
            powerSave_q <= busReq.wdata[SYS_POWER_SAVE];
        end
    end

    // Reserved bits 7 to 3 are masked on the way in, so they read as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sysOptions_q <= SYSTEM_CONFIGURATION_RESET[14:0];
        end else if (wrSys) begin
            sysOptions_q <= busReq.wdata[14:0] & 15'h7F07;
        end
    end

    assign sysConfig = {powerSave_q, sysOptions_q};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auxConfig_q <= AUXILIARY_CONFIGURATION_RESET[AUX_USED_BITS-1:0];
        end else if (wrAux) begin
            auxConfig_q <= busReq.wdata[AUX_USED_BITS-1:0];
        end
    end

    // Pin roles: 1 means clear-to-send / request-to-send
    assign cfg.port1CtsSelect = auxConfig_q[AUX_PORT1_CTS];
    assign cfg.port1RequestOutSelect = auxConfig_q[AUX_PORT1_RTS];
    assign cfg.port0CtsSelect = auxConfig_q[AUX_PORT0_CTS];
    assign cfg.port0RequestOutSelect = auxConfig_q[AUX_PORT0_RTS];
    assign cfg.lowerSpaceByteWidth = auxConfig_q[AUX_LOWER_WIDTH];
    assign cfg.middleSpaceByteWidth = auxConfig_q[AUX_MIDDLE_WIDTH];
    assign cfg.ioSpaceByteWidth = auxConfig_q[AUX_IO_WIDTH];
    assign cfg.middleSelectWholeRange = sysConfig[SYS_WHOLE_RANGE];
    assign cfg.strobePinSelect = sysConfig[SYS_STROBE_SEL];
    assign cfg.pulseDemodEnable = sysConfig[SYS_DEMOD_EN];

    // ****************************************
    // Clock divider and clock outputs
    // ****************************************
    sysc_clock_divider u_div (
        .clk(clk),
        .resetn(resetn),
        .powerSaveEnable(sysConfig[SYS_POWER_SAVE]),
        .clockDividerField(sysConfig[SYS_DIV_HI:0]),
        .divTick(divTick),
        .divClock(divClock)
    );

    // Crystal clock is asynchronous here, so it is sampled through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xtalSync_q <= 2'h0;
        end else begin
            xtalSync_q <= {xtalSync_q[0], xtalClock};
        end
    end

    // Limitation: the crystal path is a sampled view, not a clean clock
    assign clockSelA = sysConfig[SYS_CLKA_SRC] ? xtalSync_q[1] : divClock;
    assign clockSelB = sysConfig[SYS_CLKB_SRC] ? xtalSync_q[1] : divClock;

    // Registered so that a change of source never glitches the pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clockOutA <= 1'b0;
        end else begin
            clockOutA <= !sysConfig[SYS_CLKA_LOW] && clockSelA;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clockOutB <= 1'b0;
        end else begin
            clockOutB <= !sysConfig[SYS_CLKB_LOW] && clockSelB;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    assign wdTimeout = wdog_q[WD_ENABLE] && wdExponent != 5'h00
                       && wdCount_q == WD_CNT_W'((28'h1 << wdExponent) - 28'h1);

    // A write to the control register restarts the timeout period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdCount_q <= '0;
        end else if (!wdog_q[WD_ENABLE] || wdTimeout || wrWd) begin
            wdCount_q <= '0;
        end else begin
            wdCount_q <= wdCount_q + WD_CNT_W'(1);
        end
    end

    // Flags: set on timeout beats a software clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdog_q <= WDOG_RESET;
        end else begin
            if (wrWd) begin
                wdog_q <= busReq.wdata & 16'hF8FF;
                // Chip-test bit is never stored, whatever software writes
                wdog_q[WD_TEST] <= 1'b0;
            end
            if (wdTimeout) begin
                wdog_q[WD_TIMEOUT_FLAG] <= 1'b1;
                if (!wdResetCause) begin
                    wdog_q[WD_NMI_FLAG] <= 1'b1;
                end
            end
        end
    end

    // A set NMI flag turns the next timeout into a reset, whatever the select bit says
    assign wdResetCause = wdog_q[WD_RESET_SEL] || wdog_q[WD_NMI_FLAG];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdogReset <= 1'b0;
        end else begin
            watchdogReset <= wdTimeout && wdResetCause;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdogNmi <= 1'b0;
        end else begin
            watchdogNmi <= wdTimeout && !wdResetCause;
        end
    end

    // ****************************************
    // Refresh counter
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refreshInterval_q <= REFRESH_INTERVAL_RESET;
        end else if (wrRefInt) begin
            refreshInterval_q <= busReq.wdata[REF_COUNT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refreshEnable_q <= REFRESH_EN_RESET[REF_ENABLE];
        end else if (wrRefEn) begin
            refreshEnable_q <= busReq.wdata[REF_ENABLE];
        end
    end

    // Terminal count is the step from one down to zero
    assign refreshTerminal = refreshEnable_q && refreshCount_q == REF_COUNT_W'(1);

    // Counts down on the processor clock; refresh address lives elsewhere
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refreshCount_q <= '0;
        end else if (!refreshEnable_q) begin
            refreshCount_q <= '0;
        end else if (refreshCount_q == '0) begin
            refreshCount_q <= refreshInterval_q;
        end else begin
            refreshCount_q <= refreshCount_q - REF_COUNT_W'(1);
        end
    end

    // One request per period: the reload cycle raises none
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refreshRequest <= 1'b0;
        end else begin
            refreshRequest <= refreshTerminal;
        end
    end

    assign middleChipSelect3IsRefresh = refreshEnable_q;

    // ****************************************
    // Read mux
    // ****************************************
    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        case (busReq.addr)
            SYSTEM_CONFIGURATION_OFS: readData = sysConfig;
            AUXILIARY_CONFIGURATION_OFS: readData = {9'h000, auxConfig_q};
            WATCHDOG_CONTROL_OFS: readData = wdog_q;
            REFRESH_ENABLE_COUNTER_OFS: readData = {refreshEnable_q, 6'h00, refreshCount_q};
            REFRESH_INTERVAL_OFS: readData = {7'h00, refreshInterval_q};
            default: readData = 16'h0000;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busRdata <= 16'h0000;
        end else if (busReq.rd) begin
            busRdata <= readData;
        end
    end
endmodule

// *** tb/sysc_config_block_properties.sv ***
// Checker: port-level properties of the configuration block
module sysc_config_block_checker
    import sysc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Observed ports
    input wire sysc_pkg::sysc_req_s busReq,
    input wire logic [15:0] busRdata,
    input wire logic hwInterrupt,
    input wire sysc_pkg::sysc_cfg_s cfg,
    input wire logic clockOutA,
    input wire logic clockOutB,
    input wire logic divTick,
    input wire logic watchdogNmi,
    input wire logic watchdogReset,
    input wire logic refreshRequest,
    input wire logic middleChipSelect3IsRefresh
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic auxWr;
    logic sysWr;
    logic refWr;
    assign auxWr = busReq.wr && busReq.addr == AUXILIARY_CONFIGURATION_OFS;
    assign sysWr = busReq.wr && busReq.addr == SYSTEM_CONFIGURATION_OFS;
    assign refWr = busReq.wr && busReq.addr == REFRESH_ENABLE_COUNTER_OFS;
    property p_aux_cfg; auxWr |=> cfg[9:3] == $past(busReq.wdata[6:0]); endproperty
    a_aux_cfg: assert property (p_aux_cfg) else $error("aux pin roles wrong");
    property p_sys_cfg; sysWr |=> cfg[2:0] == $past(busReq.wdata[14:12]); endproperty
    a_sys_cfg: assert property (p_sys_cfg) else $error("sys options wrong");
    property p_ref_sel; refWr |=> middleChipSelect3IsRefresh == $past(busReq.wdata[15]); endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("refresh select wrong");
    // A disable can meet a pulse already launched, so only a settled disable is judged
    property p_ref_idle;
        !middleChipSelect3IsRefresh && !$past(middleChipSelect3IsRefresh) |-> !refreshRequest;
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh while off");
    property p_psave_clr; hwInterrupt |=> divTick; endproperty
    a_psave_clr: assert property (p_psave_clr) else $error("power save kept");
    property p_clka_low; sysWr && busReq.wdata[8] ##1 !sysWr |=> !clockOutA; endproperty
    a_clka_low: assert property (p_clka_low) else $error("clock A not low");
    property p_clkb_low; sysWr && busReq.wdata[10] ##1 !sysWr |=> !clockOutB; endproperty
    a_clkb_low: assert property (p_clkb_low) else $error("clock B not low");
    property p_cnt_rsvd;
        busReq.rd && busReq.addr == REFRESH_ENABLE_COUNTER_OFS |=> busRdata[14:9] == 6'h00;
    endproperty
    a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("counter reserved set");
    property p_int_rsvd;
        busReq.rd && busReq.addr == REFRESH_INTERVAL_OFS |=> busRdata[15:9] == 7'h00;
    endproperty
    a_int_rsvd: assert property (p_int_rsvd) else $error("interval upper set");
    property p_nmi_excl; watchdogNmi |-> !watchdogReset ##1 !watchdogNmi; endproperty
    a_nmi_excl: assert property (p_nmi_excl) else $error("nmi with reset");
    property p_ref_once; refreshRequest |=> !refreshRequest; endproperty
    a_ref_once: assert property (p_ref_once) else $error("refresh held two cycles");
    c_nmi: cover property (watchdogNmi);
    c_reset: cover property (watchdogReset);
    c_refresh: cover property (refreshRequest);
endmodule

bind sysc_config_block sysc_config_block_checker u_sysc_config_block_checker (
    .clk(clk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
    .hwInterrupt(hwInterrupt), .cfg(cfg), .clockOutA(clockOutA), .clockOutB(clockOutB),
    .divTick(divTick), .watchdogNmi(watchdogNmi), .watchdogReset(watchdogReset),
    .refreshRequest(refreshRequest), .middleChipSelect3IsRefresh(middleChipSelect3IsRefresh)
);

// *** tb/testbench.sv ***
// Testbench: self-checking scenarios for the configuration block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sysc_pkg::*;
    // ********
    // Stimulus and design
    // ********
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hwInterrupt = 1'b0;
    logic swInterrupt = 1'b0;
    logic xtalClock = 1'b0;
    sysc_req_s busReq = '0;
    logic [15:0] busRdata;
    logic [15:0] rdv;
    sysc_cfg_s cfg;
    logic clockOutA, clockOutB, divTick, watchdogNmi, watchdogReset, refreshRequest, mcs3Rf;
    int mismatches = 0;
    int checks = 0;
    always #50 clk = ~clk;
    // Crystal period unrelated to clk so the synchroniser sees real phase drift
    always #173 xtalClock = ~xtalClock;
    sysc_config_block u_sysc_config_block (
        .clk(clk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
        .hwInterrupt(hwInterrupt), .swInterrupt(swInterrupt), .xtalClock(xtalClock),
        .cfg(cfg), .clockOutA(clockOutA), .clockOutB(clockOutB), .divTick(divTick),
        .watchdogNmi(watchdogNmi), .watchdogReset(watchdogReset),
        .refreshRequest(refreshRequest), .middleChipSelect3IsRefresh(mcs3Rf)
    );
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(negedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rdChk(logic [7:0] a, logic [15:0] exp);
        @(negedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        busReq.rd <= 1'b0;
        rdv = busRdata;
        check($sformatf("reg %h", a), rdv, exp);
    endtask
    // Event select: 0 nmi, 1 reset, 2 refresh, 3 either watchdog pulse
    task automatic waitEv(int sel, int lim, bit must, output int c);
        logic [3:0] ev;
        c = 0;
        ev = 4'h0;
        while (ev[sel] !== 1'b1 && c < lim) begin
            @(negedge clk);
            c++;
            ev = {watchdogNmi | watchdogReset, refreshRequest, watchdogReset, watchdogNmi};
        end
        if (must && c >= lim) begin
            mismatches++;
            $display("Error event %0d expected pulse seen none", sel);
            test_done();
        end
    endtask
    task automatic pulse(bit hw);
        @(negedge clk);
        if (hw) begin
            hwInterrupt <= 1'b1;
        end else begin
            swInterrupt <= 1'b1;
        end
        @(negedge clk);
        hwInterrupt <= 1'b0;
        swInterrupt <= 1'b0;
    endtask
    task automatic resetValues();
        rdChk(REFRESH_ENABLE_COUNTER_OFS, 16'h0000);
        rdChk(WATCHDOG_CONTROL_OFS, 16'hC080);
        rdChk(SYSTEM_CONFIGURATION_OFS, 16'h0000);
        rdChk(AUXILIARY_CONFIGURATION_OFS, 16'h0000);
        rdChk(REFRESH_INTERVAL_OFS, 16'h0000);
        rdChk(8'hE0, 16'h0000);
        check("refresh select", mcs3Rf, 1'b0);
    endtask
    task automatic auxCfg();
        wr(AUXILIARY_CONFIGURATION_OFS, 16'hFFFF);
        rdChk(AUXILIARY_CONFIGURATION_OFS, 16'h007F);
        check("aux cfg", cfg[9:3], 7'h7F);
        wr(AUXILIARY_CONFIGURATION_OFS, 16'h0055);
        check("aux cfg", cfg[9:3], 7'h55);
    endtask
    task automatic sysCfg();
        int a;
        int b;
        wr(SYSTEM_CONFIGURATION_OFS, 16'hFFFF);
        rdChk(SYSTEM_CONFIGURATION_OFS, 16'hFF07);
        check("sys cfg", cfg[2:0], 3'h7);
        check("clocks", {clockOutA, clockOutB}, 2'b00);
        wr(SYSTEM_CONFIGURATION_OFS, 16'h0000);
        repeat (2) @(negedge clk);
        check("clocks", {clockOutA, clockOutB}, 2'b11);
        wr(SYSTEM_CONFIGURATION_OFS, 16'h0A00);
        check("sys cfg", cfg[2:0], 3'h0);
        a = 0;
        b = 0;
        repeat (40) begin
            @(negedge clk);
            a += clockOutA;
            b += clockOutB;
        end
        check("xtal follow", {a > 5 && a < 35, b > 5 && b < 35}, 2'b11);
    endtask
    task automatic powerSave();
        int c;
        for (int f = 0; f < 8; f++) begin
            wr(SYSTEM_CONFIGURATION_OFS, 16'h8000 | 16'(f));
            repeat (128) @(negedge clk);
            c = 0;
            repeat (256) begin
                @(negedge clk);
                c += divTick;
            end
            check("div ticks", c, 256 >> f);
        end
        pulse(1'b0);
        rdChk(SYSTEM_CONFIGURATION_OFS, 16'h8007);
        pulse(1'b1);
        rdChk(SYSTEM_CONFIGURATION_OFS, 16'h0007);
        c = 0;
        repeat (16) begin
            @(negedge clk);
            c += divTick;
        end
        check("undivided ticks", c, 16);
    endtask
    task automatic watchdog();
        int c;
        wr(WATCHDOG_CONTROL_OFS, 16'h0081);
        waitEv(3, 1100, 1'b0, c);
        check("disabled wait", c, 1100);
        // Bits 7 and 0 both set: the lowest one must pick the short timeout
        wr(WATCHDOG_CONTROL_OFS, 16'h8081);
        waitEv(3, 1100, 1'b1, c);
        check("nmi", {watchdogNmi, c >= 1020 && c <= 1028}, 2'b11);
        rdChk(WATCHDOG_CONTROL_OFS, 16'hB081);
        waitEv(3, 1100, 1'b1, c);
        check("reset after nmi", {watchdogReset, watchdogNmi}, 2'b10);
        rdChk(WATCHDOG_CONTROL_OFS, 16'hB081);
        wr(WATCHDOG_CONTROL_OFS, 16'hC081);
        rdChk(WATCHDOG_CONTROL_OFS, 16'hC081);
        waitEv(3, 1100, 1'b1, c);
        check("reset select", {watchdogReset, watchdogNmi}, 2'b10);
        rdChk(WATCHDOG_CONTROL_OFS, 16'hE081);
        // External reset in mid-run clears the sticky flag and restores the default
        @(negedge clk);
        resetn <= 1'b0;
        repeat (2) @(negedge clk);
        resetn <= 1'b1;
        rdChk(WATCHDOG_CONTROL_OFS, WDOG_RESET);
        wr(WATCHDOG_CONTROL_OFS, 16'h0081);
    endtask
    task automatic refresh();
        int c;
        // Power-save is off here, so the interval needs no scaling
        wr(REFRESH_INTERVAL_OFS, 16'hFE05);
        rdChk(REFRESH_INTERVAL_OFS, 16'h0005);
        wr(REFRESH_ENABLE_COUNTER_OFS, 16'h8000);
        check("refresh select", mcs3Rf, 1'b1);
        waitEv(2, 20, 1'b1, c);
        waitEv(2, 20, 1'b1, c);
        check("refresh period", c, 6);
        // The read is taken one cycle after the reload, so the counter shows the interval
        rdChk(REFRESH_ENABLE_COUNTER_OFS, 16'h8005);
        check("counter range", rdv[8:0] <= 9'h005, 1'b1);
        wr(REFRESH_ENABLE_COUNTER_OFS, 16'h0000);
        rdChk(REFRESH_ENABLE_COUNTER_OFS, 16'h0000);
        waitEv(2, 30, 1'b0, c);
        check("refresh stopped", c, 30);
    endtask
    initial begin
        #(100 * 60000);
        mismatches++;
        $display("Error run time expected end seen limit");
        test_done();
    end
    initial begin
        repeat (4) @(negedge clk);
        resetn <= 1'b1;
        resetValues();
        auxCfg();
        sysCfg();
        powerSave();
        watchdog();
        refresh();
        test_done();
    end
endmodule
